// >>> rtl/dsw_pkg.sv
/*
  Constants shared by the serial write port of the dual converter:
  frame length, command word layout, mode codes and reset values.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package dsw_pkg;

  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned CODE_W     = 10;

  localparam logic [CNT_W-1:0] LAST_BIT_CNT = 5'h0f;
  localparam logic [CNT_W-1:0] FULL_CNT     = 5'h10;

  // Command word fields
  localparam int unsigned ADDR_HI = 15;
  localparam int unsigned ADDR_LO = 14;
  localparam int unsigned MODE_HI = 13;
  localparam int unsigned MODE_LO = 12;
  localparam int unsigned DATA_HI = 11;
  localparam int unsigned DATA_LO = 2;
  localparam int unsigned TERM_HI = 11;
  localparam int unsigned TERM_LO = 10;

  localparam logic [1:0] ADDR_CHAN_A = 2'h0;
  localparam logic [1:0] ADDR_CHAN_B = 2'h1;

  typedef enum logic [1:0] {
    DSW_MODE_LOAD       = 2'h0,
    DSW_MODE_LOAD_UPD   = 2'h1,
    DSW_MODE_ALL_UPD    = 2'h2,
    DSW_MODE_POWER_DOWN = 2'h3
  } dsw_mode_e;

  localparam logic [CODE_W-1:0]     CODE_RESET = 10'h000;
  localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [1:0]            TERM_RESET = 2'h0;

endpackage : dsw_pkg

`default_nettype wire

// >>> rtl/dsw_shift_rx.sv
/*
  Link side of the serial write port: shifts the data line on falling
  shift-clock edges while the frame select is low and hands each full
  word over by a toggle. Assumes the shift clock may stop between
  frames, so the frame select itself clears the bit count.
*/
`default_nettype none

module dsw_shift_rx
  import dsw_pkg::*;
(
  input  wire logic                  shiftClk,    // Link shift clock
  input  wire logic                  nrst,        // Raw reset, active low
  input  wire logic                  frameSelN,   // Frame select, active low
  input  wire logic                  serialData,  // Serial data line
  output var  logic [FRAME_BITS-1:0] holdWord_q,  // Last complete word
  output var  logic                  wordTgl_q    // Flips per complete word
);

  logic [CNT_W-1:0]      bitCnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  wire                   frameIdle = frameSelN | ~nrst;
  wire                   lastBit   = (bitCnt_q == LAST_BIT_CNT);
  wire                   counting  = (bitCnt_q != FULL_CNT);

  // Select high clears the partial frame without needing a clock edge
  always_ff @(negedge shiftClk or posedge frameIdle) begin
    if (frameIdle) begin
      bitCnt_q <= '0;
      shift_q  <= WORD_RESET;
    end else if (counting) begin
      bitCnt_q <= bitCnt_q + 5'h01;
      shift_q  <= {shift_q[FRAME_BITS-2:0], serialData};
    end
  end

  always_ff @(negedge shiftClk or negedge nrst) begin
    if (!nrst) begin
      holdWord_q <= WORD_RESET;
      wordTgl_q  <= 1'b0;
    end else if (!frameSelN && lastBit) begin
      holdWord_q <= {shift_q[FRAME_BITS-2:0], serialData};
      wordTgl_q  <= ~wordTgl_q;
    end
  end

endmodule // dsw_shift_rx

`default_nettype wire

// >>> rtl/dsw_write_port.sv
/*
  Serial write port of a dual 10-bit converter: link logic on the
  shift clock, word decode and output codes on mclk. Assumes mclk is
  much faster than the word rate (16 shift clocks per word).
*/
`default_nettype none

module dsw_write_port
  import dsw_pkg::*;
(
  input  wire logic              mclk,           // System clock, 50 MHz
  input  wire logic              nrst,           // Async reset, active low
  input  wire logic              shiftClk,       // Link shift clock
  input  wire logic              frameSelN,      // Frame select, active low
  input  wire logic              serialData,     // Serial data line
  output var  logic [CODE_W-1:0] channelAOutput, // Channel A output code
  output var  logic [CODE_W-1:0] channelBOutput, // Channel B output code
  output var  logic              powerDown_q,    // Both outputs powered down
  output var  logic [1:0]        pdTerm_q,       // Power-down termination
  output var  logic              wordSeen_q      // Pulse per received word
);

  logic                  rstSync1_q;
  logic                  rstSync2_q;
  logic [FRAME_BITS-1:0] holdWord;
  logic                  wordTgl;
  logic                  tglSync1_q;
  logic                  tglSync2_q;
  logic                  tglSync3_q;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  wire rstN = rstSync2_q;

  dsw_shift_rx uRx (
    .shiftClk   (shiftClk),
    .nrst       (nrst),
    .frameSelN  (frameSelN),
    .serialData (serialData),
    .holdWord_q (holdWord),
    .wordTgl_q  (wordTgl)
  );

  // Word-done toggle crosses into mclk; the held word is stable long
  // before the next toggle, so it is sampled after the toggle settles
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      tglSync1_q <= 1'b0;
      tglSync2_q <= 1'b0;
      tglSync3_q <= 1'b0;
    end else begin
      tglSync1_q <= wordTgl;
      tglSync2_q <= tglSync1_q;
      tglSync3_q <= tglSync2_q;
    end
  end

  wire newWord = tglSync2_q ^ tglSync3_q;

  // Field decode of the received word
  wire [1:0]        wordAddr = holdWord[ADDR_HI:ADDR_LO];
  wire [1:0]        wordMode = holdWord[MODE_HI:MODE_LO];
  wire [CODE_W-1:0] wordCode = holdWord[DATA_HI:DATA_LO];
  wire [1:0]        wordTerm = holdWord[TERM_HI:TERM_LO];

  wire isLoad  = (wordMode == DSW_MODE_LOAD);
  wire isLdUpd = (wordMode == DSW_MODE_LOAD_UPD);
  wire isAll   = (wordMode == DSW_MODE_ALL_UPD);
  wire isPdown = (wordMode == DSW_MODE_POWER_DOWN);
  wire addrA   = (wordAddr == ADDR_CHAN_A);
  wire addrB   = (wordAddr == ADDR_CHAN_B);

  wire       upd     = newWord & (((addrA | addrB) & isLdUpd) | isAll);
  wire       pdwn    = newWord & isPdown;
  wire [1:0] chanHit = {addrB, addrA};

  // Per channel: input register, then output code; zero until a word
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    logic [CODE_W-1:0] chanReg_q;
    logic [CODE_W-1:0] chanOut_q;
    wire               chanWr    = newWord &
                                   ((chanHit[ch] & (isLoad | isLdUpd)) |
                                    isAll);
    wire [CODE_W-1:0]  chanReg_d = chanWr ? wordCode : chanReg_q;

    always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
        chanReg_q <= CODE_RESET;
      end else begin
        chanReg_q <= chanReg_d;
      end
    end

    always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
        chanOut_q <= CODE_RESET;
      end else if (upd) begin
        chanOut_q <= chanReg_d;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      powerDown_q <= 1'b0;
      pdTerm_q    <= TERM_RESET;
    end else if (pdwn) begin
      powerDown_q <= 1'b1;
      pdTerm_q    <= wordTerm;
    end else if (upd) begin
      powerDown_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wordSeen_q <= 1'b0;
    end else begin
      wordSeen_q <= newWord;
    end
  end

  assign channelAOutput = gChan[0].chanOut_q;
  assign channelBOutput = gChan[1].chanOut_q;

endmodule // dsw_write_port

`default_nettype wire

// >>> verif/dsw_write_port_monitor.sv
/* Checker for the serial write port outputs.
   Sees only the top ports; bound to every instance. */
`default_nettype none
module dsw_write_port_monitor
  import dsw_pkg::*;
(
  input wire logic              mclk,           // Clock
  input wire logic              nrst,           // Reset
  input wire logic              shiftClk,       // Link clock
  input wire logic              frameSelN,      // Select
  input wire logic              serialData,     // Data
  input wire logic [CODE_W-1:0] channelAOutput, // Code A
  input wire logic [CODE_W-1:0] channelBOutput, // Code B
  input wire logic              powerDown_q,    // Powered down
  input wire logic [1:0]        pdTerm_q,       // Termination
  input wire logic              wordSeen_q      // Word pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seenAny_q;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) seenAny_q <= 1'b0;
    else if (wordSeen_q) seenAny_q <= 1'b1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_SPACING: assert property (wordSeen_q |=> !wordSeen_q [*8])
    else $error("word pulses too close");
  AST_A_CAUSE: assert property ($changed(channelAOutput) |-> wordSeen_q)
    else $error("code A moved without a word");
  AST_B_CAUSE: assert property ($changed(channelBOutput) |-> wordSeen_q)
    else $error("code B moved without a word");
  AST_PD_CAUSE: assert property ($changed(powerDown_q) |-> wordSeen_q)
    else $error("power state moved without a word");
  AST_TERM: assert property ($changed(pdTerm_q) |-> powerDown_q)
    else $error("termination moved outside power down");
  AST_PD_KEEP: assert property ($rose(powerDown_q) |->
    $stable(channelAOutput) && $stable(channelBOutput))
    else $error("power down altered a code");
  AST_ZERO: assert property ((channelAOutput | channelBOutput) != 10'h000
    |-> ##1 (seenAny_q || wordSeen_q))
    else $error("nonzero code before any word");
endmodule // dsw_write_port_monitor

bind dsw_write_port dsw_write_port_monitor u_mon (.mclk, .nrst, .shiftClk,
  .frameSelN, .serialData, .channelAOutput, .channelBOutput, .powerDown_q,
  .pdTerm_q, .wordSeen_q);
`default_nettype wire

// >>> verif/dsw_host_model.sv
/* Host model of the three-wire bus: 48 ns shift clock, idle high,
   running only inside frames. Called through its send task. */
`default_nettype none
module dsw_host_model (
  output var logic shiftClk,   // Shift clock
  output var logic frameSelN,  // Select
  output var logic serialData  // Data, MSB first
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shiftClk = 1'b1;
    frameSelN = 1'b1;
    serialData = 1'b0;
  end
  // Fewer than 16 bits aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    frameSelN = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serialData = w[i];
      #12 shiftClk = 1'b0;
      #24 shiftClk = 1'b1;
      #12;
    end
    #12 frameSelN = 1'b1;
    serialData = ~serialData;
    #48;
  endtask
endmodule // dsw_host_model
`default_nettype wire

// >>> verif/dsw_write_port_bench.sv
/* Testbench for the serial write port.
   Needs the host model and the bound checker. */
`default_nettype none
module dsw_write_port_bench;
  import dsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  wire logic         sck, fsn, sdi;
  logic [CODE_W-1:0] codeA, codeB;
  logic              pd, seen;
  logic [1:0]        term;
  int                num_errors = 0;
  int                checks_done = 0;
  int                wordCount = 0;
  always #10 mclk = ~mclk;
  // Counts received-word pulses away from their launching edge
  always @(negedge mclk) begin
    if (seen === 1'b1) begin
      wordCount++;
    end
  end
  dsw_host_model host (.shiftClk(sck), .frameSelN(fsn), .serialData(sdi));
  dsw_write_port DUT (.mclk(mclk), .nrst(nrst), .shiftClk(sck),
    .frameSelN(fsn), .serialData(sdi), .channelAOutput(codeA),
    .channelBOutput(codeB), .powerDown_q(pd), .pdTerm_q(term),
    .wordSeen_q(seen));
  function automatic logic [15:0] cmd(logic [1:0] a, m, logic [9:0] c);
    return {a, m, c, 2'h0};
  endfunction
  task automatic check(input logic [22:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] w, input int n);
    host.send(w, n);
    repeat (8) @(negedge mclk);
  endtask
  task automatic tReset;
    check({pd, term, codeA, codeB}, 23'h0);
    $display("reset test done");
  endtask
  task automatic tLoad;
    put(cmd(ADDR_CHAN_A, DSW_MODE_LOAD, 10'h2a5), 16);
    check({pd, term, codeA, codeB}, 23'h0);
    put(cmd(ADDR_CHAN_B, DSW_MODE_LOAD_UPD, 10'h15a), 16);
    check({pd, term, codeA, codeB}, {3'h0, 10'h2a5, 10'h15a});
    check(23'(wordCount), 23'h2);
    $display("load test done");
  endtask
  task automatic tAbort;
    put(cmd(ADDR_CHAN_A, DSW_MODE_ALL_UPD, 10'h3ff), 15);
    check({pd, term, codeA, codeB}, {3'h0, 10'h2a5, 10'h15a});
    check(23'(wordCount), 23'h2);
    put(cmd(2'h2, DSW_MODE_LOAD_UPD, 10'h111), 16);
    check({pd, term, codeA, codeB}, {3'h0, 10'h2a5, 10'h15a});
    check(23'(wordCount), 23'h3);
    $display("abort test done");
  endtask
  task automatic tPower;
    put(cmd(ADDR_CHAN_A, DSW_MODE_POWER_DOWN, 10'h2ff), 16);
    check({pd, term, codeA, codeB}, {3'h6, 10'h2a5, 10'h15a});
    put(cmd(ADDR_CHAN_B, DSW_MODE_ALL_UPD, 10'h3ff), 16);
    check({pd, term, codeA, codeB}, {3'h2, 10'h3ff, 10'h3ff});
    check(23'(wordCount), 23'h5);
    $display("power test done");
  endtask
  task automatic tRestart;
    nrst = 1'b0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    check({pd, term, codeA, codeB}, 23'h0);
    put(cmd(ADDR_CHAN_B, DSW_MODE_LOAD_UPD, 10'h0c3), 16);
    check({pd, term, codeA, codeB}, {3'h0, 10'h000, 10'h0c3});
    $display("restart test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    tReset;
    tLoad;
    tAbort;
    tPower;
    tRestart;
    summarize;
  end
  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule // dsw_write_port_bench
`default_nettype wire
